// File: verilog/msd_cfg.svh
// Constants for the memory space decoder: address limits and the unimplemented-bit reset value.
// Assumes inclusion by bare name from the package and modules.
// Notes on behaviour
// [R1] Direct or indirect accesses to 00H-7FH hit the lower data RAM.
// [R2] The indirect space covers 256 bytes, 00H-FFH, register-indirect only.
// [R3] Indirect 00H-7FH share lower RAM; indirect 80H-FFH hit upper RAM.
// [R4] Special function registers are reached by direct addressing only.
// [R5] Direct 80H and up go to the SFR space, indirect there to upper RAM.
// [R6] The external move decodes a 64 kB space, from the pointer or R0/R1.
// [R7] On-chip auxiliary RAM is 256, 768 or 1792 bytes by variant.
// [R8] A 64 kB code space is read by fetch and code reads; 16/32/64 kB on chip.
// [R9] Expanded RAM is reachable only with the select bit set and a move.
// [R10] Expanded RAM occupies auxiliary addresses from 000H to its top.
// [R11] With the select bit set, moves beyond on-chip RAM go off chip.
// [R12] With the select bit clear, every external move goes off chip.
// [R13] Software keeps the stack within the 256-byte internal RAM.
// [R14] Unimplemented SFR bits read unknown; their reset value is zero.
// [R15] Software avoids writing ones to unimplemented SFR bits.
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
// ****************************************
// Address limits and unimplemented-bit reset value
// ****************************************
`define MSD_LOW_TOP       8'h7F
`define MSD_SFR_BASE      8'h80
`define MSD_AUX_TOP_V0    16'h00FF
`define MSD_AUX_TOP_V1    16'h02FF
`define MSD_AUX_TOP_V2    16'h06FF
`define MSD_CODE_TOP_V0   16'h3FFF
`define MSD_CODE_TOP_V1   16'h7FFF
`define MSD_CODE_TOP_V2   16'hFFFF
`define MSD_UNIMP_RESET   8'h00
`endif

// File: verilog/msd_pkg.sv
// Types shared by the memory space decoder modules.
// Assumes the constants header is on the include path.
package msd_pkg;
    `include "msd_cfg.svh"
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        MSD_SP_NONE  = 3'h0,
        MSD_SP_LOW   = 3'h1,
        MSD_SP_UPPER = 3'h2,
        MSD_SP_SFR   = 3'h3,
        MSD_SP_XINT  = 3'h4,
        MSD_SP_XEXT  = 3'h5,
        MSD_SP_CINT  = 3'h6,
        MSD_SP_CEXT  = 3'h7
    } msd_space_type;
    typedef enum logic [2:0] {
        MSD_AM_DIRECT   = 3'h0,
        MSD_AM_INDIRECT = 3'h1,
        MSD_AM_XMOVE    = 3'h2,
        MSD_AM_CODE     = 3'h3,
        MSD_AM_FETCH    = 3'h4
    } msd_mode_type;
    typedef enum logic [1:0] {
        MSD_ST_IDLE = 2'b00,
        MSD_ST_HOLD = 2'b01
    } msd_state_type;
endpackage

// File: verilog/msd_route_if.sv
// Carries one decoded access between the decoder and its output stage.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface msd_route_if;
    import msd_pkg::*;
    logic          valid;
    msd_space_type space;
    logic [15:0]   addr;
    logic          write;
    modport src (output valid, output space, output addr, output write);
    modport dst (input valid, input space, input addr, input write);
endinterface

// File: verilog/msd_route_reg.sv
// Output register stage for decoded accesses.
// Assumes inputs synchronous to clk_i.
`timescale 1ns/1ps
module msd_route_reg
    import msd_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    msd_route_if.dst    rt,
    output logic        valid_o,
    output logic [2:0]  space_o,
    output logic [15:0] addr_o,
    output logic        write_o
);
    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            space_o <= 3'h0;
            addr_o  <= 16'h0000;
            write_o <= 1'b0;
        end else begin
            valid_o <= rt.valid;
            space_o <= rt.space;
            addr_o  <= rt.addr;
            write_o <= rt.write;
        end
    end
endmodule

// File: verilog/msd_top.sv
// Memory space decoder top: steers each CPU access to its space.
// Assumes the CPU presents one access per cycle on req_i.
`timescale 1ns/1ps
`include "msd_cfg.svh"
module msd_top
    import msd_pkg::*;
#(
    parameter logic [1:0] VARIANT = 2'd0
)
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   req_i,
    input  wire logic   write_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [15:0] addr_i,
    input  wire logic   aux_ram_select_i,
    input  wire logic   code_ext_only_i,
    output logic        valid_o,
    output logic [2:0]  space_o,
    output logic [15:0] addr_o,
    output logic        write_o,
    output logic [7:0]  unimp_bits_o
);
    // ****************************************
    // Variant limits
    // ****************************************
    function automatic logic [15:0] aux_top(input logic [1:0] v);
        case (v)
            2'd1:    aux_top = `MSD_AUX_TOP_V1;
            2'd2:    aux_top = `MSD_AUX_TOP_V2;
            default: aux_top = `MSD_AUX_TOP_V0;
        endcase
    endfunction
    function automatic logic [15:0] code_top(input logic [1:0] v);
        case (v)
            2'd1:    code_top = `MSD_CODE_TOP_V1;
            2'd2:    code_top = `MSD_CODE_TOP_V2;
            default: code_top = `MSD_CODE_TOP_V0;
        endcase
    endfunction

    wire logic [15:0] aux_lim  = aux_top(VARIANT);   // [R7]
    wire logic [15:0] code_lim = code_top(VARIANT);  // [R8]

    // ****************************************
    // Decode
    // ****************************************
    wire logic [7:0] low_addr   = addr_i[7:0];
    wire logic       above_low  = low_addr >= `MSD_SFR_BASE;
    wire logic       aux_inside = addr_i <= aux_lim;
    wire logic       code_in    = !code_ext_only_i && (addr_i <= code_lim);
    // Direct: low RAM, else SFR space
    wire msd_space_type dir_sp  = above_low ? MSD_SP_SFR    // [R4] [R5]
                                            : MSD_SP_LOW;   // [R1]
    // Indirect: never SFR; upper half is separate upper RAM
    wire msd_space_type ind_sp  = above_low ? MSD_SP_UPPER  // [R2] [R3] [R5]
                                            : MSD_SP_LOW;   // [R1] [R3]
    // External move over 64 kB
    wire logic xint = aux_ram_select_i && aux_inside;      // [R9] [R10]
    wire msd_space_type xmv_sp  = xint ? MSD_SP_XINT        // [R6]
                                       : MSD_SP_XEXT;       // [R11] [R12]
    wire msd_space_type code_sp = code_in ? MSD_SP_CINT     // [R8]
                                          : MSD_SP_CEXT;
    msd_space_type sel_sp;
    always_comb begin
        case (msd_mode_type'(mode_i))
            MSD_AM_DIRECT:   sel_sp = dir_sp;
            MSD_AM_INDIRECT: sel_sp = ind_sp;
            MSD_AM_XMOVE:    sel_sp = xmv_sp;
            MSD_AM_CODE:     sel_sp = code_sp;
            MSD_AM_FETCH:    sel_sp = code_sp;
            default:         sel_sp = MSD_SP_NONE;
        endcase
    end
    wire logic mode_ok = sel_sp != MSD_SP_NONE;
    wire logic wr_ok   = write_i && (mode_i != MSD_AM_CODE)
                         && (mode_i != MSD_AM_FETCH);
    // Internal data spaces carry an 8-bit address
    wire logic narrow  = (mode_i == MSD_AM_DIRECT)
                         || (mode_i == MSD_AM_INDIRECT);
    wire logic [15:0] fwd_addr = narrow ? {8'h00, low_addr} : addr_i;

    // ****************************************
    // State
    // ****************************************
    msd_state_type state_r;
    msd_state_type state_nxt;
    always_comb begin
        case (state_r)
            MSD_ST_IDLE: state_nxt = (req_i && mode_ok) ? MSD_ST_HOLD
                                                        : MSD_ST_IDLE;
            MSD_ST_HOLD: state_nxt = (req_i && mode_ok) ? MSD_ST_HOLD
                                                        : MSD_ST_IDLE;
            default:     state_nxt = MSD_ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= MSD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    msd_route_if rt ();
    assign rt.valid = req_i && mode_ok;
    assign rt.space = req_i ? sel_sp : MSD_SP_NONE;
    assign rt.addr  = req_i ? fwd_addr : 16'h0000;
    assign rt.write = req_i && mode_ok && wr_ok;

    msd_route_reg u_reg (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .rt      (rt),
        .valid_o (valid_o),
        .space_o (space_o),
        .addr_o  (addr_o),
        .write_o (write_o)
    );

    // Unimplemented SFR bit value; read as zero here
    assign unimp_bits_o = `MSD_UNIMP_RESET;  // [R14]
endmodule

// File: verification/msd_monitor.sv
// Checker: route of each decoded access, address of data and move accesses, no write on code or fetch accesses.
// Assumes binding to msd_top, one clock domain.
`timescale 1ns/1ps
module msd_monitor #(parameter logic [1:0] VARIANT = 2'd0) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        req_i,
    input wire logic        write_i,
    input wire logic [2:0]  mode_i,
    input wire logic [15:0] addr_i,
    input wire logic        aux_ram_select_i,
    input wire logic        code_ext_only_i,
    input wire logic        valid_o,
    input wire logic [2:0]  space_o,
    input wire logic [15:0] addr_o,
    input wire logic        write_o,
    input wire logic [7:0]  unimp_bits_o
);
    // ****************************************
    // Previous access
    // ****************************************
    localparam logic [15:0] TOP = VARIANT == 0 ? 16'h00FF :
                                  VARIANT == 1 ? 16'h02FF : 16'h06FF;
    localparam logic [15:0] CTOP = VARIANT == 0 ? 16'h3FFF :
                                   VARIANT == 1 ? 16'h7FFF : 16'hFFFF;
    logic        tk_r;
    logic [2:0]  m_r;
    logic [15:0] a_r;
    logic        s_r;
    logic        c_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) tk_r <= 1'b0;
        else tk_r <= req_i;
    end
    always_ff @(posedge clk_i) begin
        {m_r, a_r, s_r, c_r} <= {mode_i, addr_i, aux_ram_select_i,
                                 code_ext_only_i};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence took_s(logic [2:0] m);
        tk_r && m_r == m;
    endsequence
    low_ram_a: assert property (
        tk_r && m_r < 3'h2 && !a_r[7] |-> space_o == 3'h1)
        else $error("low ram route wrong");
    sfr_route_a: assert property (
        took_s(3'h0) ##0 a_r[7] |-> space_o == 3'h3)
        else $error("sfr route wrong");
    upper_ram_a: assert property (
        took_s(3'h1) ##0 a_r[7] |-> space_o == 3'h2)
        else $error("upper ram route wrong");
    aux_int_a: assert property (
        took_s(3'h2) ##0 s_r && a_r <= TOP |-> space_o == 3'h4)
        else $error("on chip aux route wrong");
    aux_ext_a: assert property (
        took_s(3'h2) ##0 !(s_r && a_r <= TOP) |-> space_o == 3'h5)
        else $error("off chip aux route wrong");
    code_map_a: assert property (
        tk_r && (m_r == 3'h3 || m_r == 3'h4) |-> !write_o &&
        space_o == ((c_r || a_r > CTOP) ? 3'h7 : 3'h6))
        else $error("code route wrong");
    addr_fwd_a: assert property (
        took_s(3'h2) |-> addr_o == a_r)
        else $error("aux address not forwarded");
    valid_link_a: assert property (
        valid_o == (tk_r && m_r < 3'h5))
        else $error("valid not tied to request");
    narrow_addr_a: assert property (
        tk_r && m_r < 3'h2 |-> addr_o == {8'h00, a_r[7:0]})
        else $error("data address not narrowed");
    bad_mode_a: assert property (
        tk_r && m_r > 3'h4 |-> space_o == 3'h0 && !write_o)
        else $error("invalid mode not refused");
    unimp_zero_a: assert property (
        unimp_bits_o == 8'h00)
        else $error("unimplemented bits not zero");
endmodule
bind msd_top msd_monitor #(.VARIANT(VARIANT)) u_mon (.*);

// File: verification/msd_cpu_model.sv
// CPU side: one random access per cycle at falling edges.
// Assumes nothing else draws on this process's random generator.
`timescale 1ns/1ps
module msd_cpu_model (
    input  wire logic   clk_i,
    output logic        req_o,
    output logic        write_o,
    output logic [2:0]  mode_o,
    output logic [15:0] addr_o,
    output logic        sel_o,
    output logic        ext_o
);
    // ****************************************
    // Access source
    // ****************************************
    logic [15:0] edge_q [10] = '{16'h007F, 16'h0080, 16'h00FF, 16'h0100,
                                 16'h02FF, 16'h0300, 16'h06FF, 16'h0700,
                                 16'h7FFF, 16'h8000};
    // Stack traffic is modelled as indirect access only
    // Writes carry no data, so no ones reach unused bits
    initial begin
        void'($urandom(19450));
        {req_o, write_o, mode_o, addr_o, sel_o, ext_o} = '0;
        forever @(negedge clk_i) begin
            req_o <= $urandom_range(3) != 0;
            write_o <= 1'($urandom_range(1));
            mode_o <= 3'($urandom_range(7));
            sel_o <= 1'($urandom_range(1));
            ext_o <= $urandom_range(3) == 0;
            case ($urandom_range(2))
                0: addr_o <= edge_q[$urandom_range(9)];
                1: addr_o <= 16'($urandom_range(4095));
                default: addr_o <= 16'($urandom);
            endcase
        end
    end
endmodule

// File: verification/msd_top_test.sv
// Self-checking bench for the memory space decoder.
// Assumes the CPU model drives inputs at falling edges.
`timescale 1ns/1ps
module msd_top_test;
    // ****************************************
    // Bench
    // ****************************************
    localparam int AUX = 768;
    localparam int CODE = 32768;
    logic clk_i = 0, rst_b_i = 0, req_i, write_i, aux_ram_select_i;
    logic code_ext_only_i, valid_o, write_o;
    logic [2:0] mode_i, space_o;
    logic [15:0] addr_i, addr_o;
    logic [7:0] unimp_bits_o;
    int bad_count = 0, check_count = 0, eq [$], aq [$], s, a, x;
    always #2.5 clk_i = ~clk_i;
    msd_cpu_model i_cpu (.clk_i, .req_o(req_i), .write_o(write_i),
        .mode_o(mode_i), .addr_o(addr_i), .sel_o(aux_ram_select_i),
        .ext_o(code_ext_only_i));
    msd_top #(.VARIANT(2'd1)) i_dut (.*);
    // Other variants are checked by the bound monitor
    msd_top #(.VARIANT(2'h0)) i_dut_v0 (.clk_i, .rst_b_i, .req_i, .write_i,
        .mode_i, .addr_i, .aux_ram_select_i, .code_ext_only_i, .valid_o(),
        .space_o(), .addr_o(), .write_o(), .unimp_bits_o());
    msd_top #(.VARIANT(2'h2)) i_dut_v2 (.clk_i, .rst_b_i, .req_i, .write_i,
        .mode_i, .addr_i, .aux_ram_select_i, .code_ext_only_i, .valid_o(),
        .space_o(), .addr_o(), .write_o(), .unimp_bits_o());
    task automatic check(string n, int e, logic [15:0] v);
        check_count++;
        if (v !== e[15:0]) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, v);
        end
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_i) if (rst_b_i) begin
        a = mode_i < 2 ? addr_i[7:0] : addr_i;
        case (mode_i)
            0, 1: s = a < 128 ? 1 : mode_i ? 2 : 3;
            2: s = aux_ram_select_i && a < AUX ? 4 : 5;
            3, 4: s = code_ext_only_i || a >= CODE ? 7 : 6;
            default: s = 0;
        endcase
        if (!req_i) {s, a} = 0;
        eq.push_back({req_i && mode_i < 5, s[2:0],
                      req_i && mode_i < 3 && write_i});
        aq.push_back(req_i && mode_i > 4 ? -1 : a);
    end
    always @(negedge clk_i) if (eq.size()) begin
        check("route", eq.pop_front(), {valid_o, space_o, write_o});
        x = aq.pop_front();
        if (x >= 0) check("address", x, addr_o);
        check("unimp", 0, unimp_bits_o);
    end
    initial begin
        repeat (4) @(negedge clk_i);
        rst_b_i = 1;
        repeat (1500) @(negedge clk_i);
        rst_b_i = 0;
        @(negedge clk_i);
        check("reset route", 0, {valid_o, space_o, write_o});
        check("reset address", 0, addr_o);
        check("reset unimp", 0, unimp_bits_o);
        repeat (3) @(negedge clk_i);
        rst_b_i = 1;
        repeat (1500) @(negedge clk_i);
        wrap_up();
    end
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule
